// File: design/pmd_map.vh
// field codes, opcode patterns and timing counts of the parallel move decoder
`ifndef PMD_MAP_VH
`define PMD_MAP_VH

// move word patterns, matched against instruction bits 23:8
`define PMD_UPD_MASK 16'hffe0
`define PMD_UPD_PAT 16'h2040
`define PMD_REG_MASK 16'hfc00
`define PMD_REG_PAT 16'h2000
`define PMD_XMEM_MASK 16'hc800
`define PMD_XMEM_PAT 16'h4000

// field positions inside the 24-bit instruction word
`define PMD_XMEM_DIR_BIT 15
`define PMD_XMEM_LONG_BIT 14
`define PMD_CCR_LIMIT_BIT 6

// register field codes
`define PMD_RC_X0 5'h04
`define PMD_RC_X1 5'h05
`define PMD_RC_Y0 5'h06
`define PMD_RC_Y1 5'h07
`define PMD_RC_A0 5'h08
`define PMD_RC_B0 5'h09
`define PMD_RC_A2 5'h0a
`define PMD_RC_B2 5'h0b
`define PMD_RC_A1 5'h0c
`define PMD_RC_B1 5'h0d
`define PMD_RC_A 5'h0e
`define PMD_RC_B 5'h0f

// effective address modes (three mode bits)
`define PMD_EA_POST_SUB_OFF 3'h0
`define PMD_EA_POST_ADD_OFF 3'h1
`define PMD_EA_POST_DEC 3'h2
`define PMD_EA_POST_INC 3'h3
`define PMD_EA_PLAIN 3'h4
`define PMD_EA_INDEXED 3'h5
`define PMD_EA_LONG 3'h6
`define PMD_EA_PRE_DEC 3'h7
`define PMD_EA_ABS_CODE 6'h30
`define PMD_EA_IMM_CODE 6'h34

// saturation constants and reset value
`define PMD_SAT_POS 24'h7fffff
`define PMD_SAT_NEG 24'h800000
`define PMD_RST_WORD 24'h000000

// memory read latency in clocks (one registered cycle)
`define PMD_MEM_LAT_CYC 1

`endif

// File: design/pmd_limiter.v
// accumulator to 24-bit word limiter
`timescale 1ns/1ps
`include "pmd_map.vh"
module pmd_limiter (
  acc,
  word,
  clipped
);
  input wire [55:0] acc;
  output reg [23:0] word;
  output reg clipped;

  // ---------------------------------------------------------------
  // limiting
  // ---------------------------------------------------------------
  // extension in use when bits 55..47 are not all equal
  always @* begin
    clipped = (acc[55:47] != {9{acc[55]}});
    if (clipped) begin
      word = acc[55] ? `PMD_SAT_NEG : `PMD_SAT_POS;
    end else begin
      word = acc[47:24];
    end
  end
endmodule // pmd_limiter

// File: design/pmd_decode.v
// parallel move decoder: register, address update and first data memory moves
`timescale 1ns/1ps
`include "pmd_map.vh"
module pmd_decode #(
  parameter AW = 16
) (
  input wire clk_sys,
  input wire nrst,
  input wire instr_valid,
  input wire [23:0] instr_word,
  input wire ext_valid,
  input wire [23:0] ext_word,
  input wire [23:0] mem_rdata,
  input wire alu_wr_a,
  input wire alu_wr_b,
  input wire [55:0] alu_result,
  input wire limit_clear,
  input wire [3:0] dbg_sel,
  output reg ready_q,
  output reg ext_req_q,
  output reg done_q,
  output reg [AW-1:0] mem_addr_q,
  output reg [23:0] mem_wdata_q,
  output reg mem_we_q,
  output reg mem_re_q,
  output reg ccr_limit_q,
  output reg [23:0] alu_input_x_first_q,
  output reg [23:0] alu_input_x_second_q,
  output reg [23:0] alu_input_y_first_q,
  output reg [23:0] alu_input_y_second_q,
  output reg [55:0] acc_one_q,
  output reg [55:0] acc_two_q,
  output reg [AW-1:0] dbg_data_q
);
  // ---------------------------------------------------------------
  // states and kinds
  // ---------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_EXT = 2'd1;
  localparam ST_EXE = 2'd2;
  localparam ST_RD = 2'd3;
  localparam K_NONE = 2'd0;
  localparam K_REG = 2'd1;
  localparam K_UPD = 2'd2;
  localparam K_XMEM = 2'd3;

  reg [1:0] state_q;
  reg [1:0] kind_q;
  reg [5:0] ea_q;
  reg dir_q;
  reg short_q;
  reg [4:0] dst_q;
  reg [4:0] src_q;
  reg [23:0] ext_q;
  reg [AW-1:0] address_pointers [0:7];
  reg [AW-1:0] address_offsets [0:7];
  // pending address register writes, one from ea update, one from move
  reg upd_pend_q;
  reg [2:0] upd_idx_q;
  reg [AW-1:0] upd_val_q;
  reg dst_pend_q;
  reg dst_off_q;
  reg [2:0] dst_idx_q;
  reg [AW-1:0] dst_val_q;
  // arithmetic result held from the take until execute
  reg alu_wa_q;
  reg alu_wb_q;
  reg [55:0] alu_res_q;

  wire take = instr_valid & ready_q;
  wire [15:0] mv = instr_word[23:8];
  wire is_upd = (mv & `PMD_UPD_MASK) == `PMD_UPD_PAT;
  wire is_reg = ((mv & `PMD_REG_MASK) == `PMD_REG_PAT) & ~is_upd;
  wire is_xmem = (mv & `PMD_XMEM_MASK) == `PMD_XMEM_PAT;
  wire [4:0] xmem_reg = {instr_word[21:20], instr_word[18:16]};
  wire [5:0] six_field = instr_word[13:8];
  wire needs_ext = is_xmem & instr_word[`PMD_XMEM_LONG_BIT] &
    ((six_field == `PMD_EA_ABS_CODE) | (six_field == `PMD_EA_IMM_CODE));

  // ---------------------------------------------------------------
  // effective address
  // ---------------------------------------------------------------
  wire [2:0] ea_mode = ea_q[5:3];
  wire [2:0] ea_idx = ea_q[2:0];
  wire [AW-1:0] rv = address_pointers[ea_idx];
  wire [AW-1:0] nv = address_offsets[ea_idx];
  reg [AW-1:0] ea_addr;
  reg [AW-1:0] ea_new;
  reg ea_upd;

  // pointer reads see only committed values, hence the pipeline delay
  always @* begin
    ea_addr = rv;
    ea_new = rv;
    ea_upd = 1'b0;
    case (ea_mode)
      `PMD_EA_POST_SUB_OFF: begin
        ea_new = rv - nv;
        ea_upd = 1'b1;
      end
      `PMD_EA_POST_ADD_OFF: begin
        ea_new = rv + nv;
        ea_upd = 1'b1;
      end
      `PMD_EA_POST_DEC: begin
        ea_new = rv - {{(AW-1){1'b0}}, 1'b1};
        ea_upd = 1'b1;
      end
      `PMD_EA_POST_INC: begin
        ea_new = rv + {{(AW-1){1'b0}}, 1'b1};
        ea_upd = 1'b1;
      end
      `PMD_EA_INDEXED: ea_addr = rv + nv;
      `PMD_EA_PRE_DEC: begin
        ea_new = rv - {{(AW-1){1'b0}}, 1'b1};
        ea_addr = ea_new;
        ea_upd = 1'b1;
      end
      `PMD_EA_LONG: ea_addr = ext_q[AW-1:0];
      default: ea_addr = rv;
    endcase
  end

  // ---------------------------------------------------------------
  // source read
  // ---------------------------------------------------------------
  wire [23:0] lim_word;
  wire lim_clip;
  pmd_limiter u_lim (
    .acc(src_q[0] ? acc_two_q : acc_one_q),
    .word(lim_word),
    .clipped(lim_clip)
  );

  reg [23:0] src_val;
  reg src_clip;
  // operands read the values held before this instruction's writes, except a pre-decremented source pointer
  always @* begin
    src_clip = 1'b0;
    case (src_q)
      `PMD_RC_X0: src_val = alu_input_x_first_q;
      `PMD_RC_X1: src_val = alu_input_x_second_q;
      `PMD_RC_Y0: src_val = alu_input_y_first_q;
      `PMD_RC_Y1: src_val = alu_input_y_second_q;
      `PMD_RC_A0: src_val = acc_one_q[23:0];
      `PMD_RC_B0: src_val = acc_two_q[23:0];
      `PMD_RC_A2: src_val = {{16{acc_one_q[55]}}, acc_one_q[55:48]};
      `PMD_RC_B2: src_val = {{16{acc_two_q[55]}}, acc_two_q[55:48]};
      `PMD_RC_A1: src_val = acc_one_q[47:24];
      `PMD_RC_B1: src_val = acc_two_q[47:24];
      `PMD_RC_A, `PMD_RC_B: begin
        src_val = lim_word;
        src_clip = lim_clip;
      end
      default: begin
        if (src_q[4:3] == 2'b10) begin
          // a pre-decremented pointer stores its updated value
          if (kind_q == K_XMEM && ea_mode == `PMD_EA_PRE_DEC && !short_q && ea_idx == src_q[2:0]) begin
            src_val = {{(24-AW){1'b0}}, ea_new};
          end else begin
            src_val = {{(24-AW){1'b0}}, address_pointers[src_q[2:0]]};
          end
        end else if (src_q[4:3] == 2'b11) begin
          src_val = {{(24-AW){1'b0}}, address_offsets[src_q[2:0]]};
        end else begin
          src_val = `PMD_RST_WORD;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // destination write select
  // ---------------------------------------------------------------
  reg wr_en;
  reg [23:0] wr_val;
  wire mem_read = (kind_q == K_XMEM) & dir_q;
  wire is_imm = !short_q && ea_q == `PMD_EA_IMM_CODE;
  wire [AW-1:0] x_addr = short_q ? {{(AW-6){1'b0}}, ea_q} : ea_addr;

  always @* begin
    wr_en = 1'b0;
    wr_val = mem_rdata;
    if (state_q == ST_RD) begin
      wr_en = 1'b1;
    end else if (state_q == ST_EXE) begin
      if (kind_q == K_REG) begin
        wr_en = 1'b1;
        wr_val = src_val;
      end else if (mem_read && is_imm) begin
        wr_en = 1'b1;
        wr_val = ext_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencing and memory side
  // ---------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b0;
      ext_req_q <= 1'b0;
      done_q <= 1'b0;
      kind_q <= K_NONE;
      ea_q <= 6'h00;
      dir_q <= 1'b0;
      short_q <= 1'b0;
      dst_q <= 5'h00;
      src_q <= 5'h00;
      ext_q <= `PMD_RST_WORD;
      mem_addr_q <= {AW{1'b0}};
      mem_wdata_q <= `PMD_RST_WORD;
      mem_we_q <= 1'b0;
      mem_re_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_re_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          ready_q <= 1'b1;
          if (take) begin
            ready_q <= 1'b0;
            dir_q <= instr_word[`PMD_XMEM_DIR_BIT];
            short_q <= is_xmem & ~instr_word[`PMD_XMEM_LONG_BIT];
            dst_q <= is_xmem ? xmem_reg : instr_word[12:8];
            src_q <= is_xmem ? xmem_reg : instr_word[17:13];
            if (is_upd) begin
              kind_q <= K_UPD;
              ea_q <= {1'b0, instr_word[12:8]};
            end else begin
              kind_q <= is_xmem ? K_XMEM : (is_reg ? K_REG : K_NONE);
              ea_q <= six_field;
            end
            if (needs_ext) begin
              ext_req_q <= 1'b1;
              state_q <= ST_EXT;
            end else begin
              state_q <= ST_EXE;
            end
          end
        end
        ST_EXT: begin
          if (ext_valid) begin
            ext_req_q <= 1'b0;
            ext_q <= ext_word;
            state_q <= ST_EXE;
          end
        end
        ST_EXE: begin
          if (kind_q == K_XMEM && !(mem_read && is_imm)) begin
            mem_addr_q <= x_addr;
            if (mem_read) begin
              mem_re_q <= 1'b1;
              state_q <= ST_RD;
            end else begin
              mem_we_q <= 1'b1;
              mem_wdata_q <= src_val;
              done_q <= 1'b1;
              ready_q <= 1'b1;
              state_q <= ST_IDLE;
            end
          end else begin
            done_q <= 1'b1;
            ready_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_RD: begin
          done_q <= 1'b1;
          ready_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // data registers and limit flag
  // ---------------------------------------------------------------
  // arithmetic results land at execute, after the move has read its source;
  // a move to the same accumulator is the sequencer's fault, the move wins
  wire lim_event = (state_q == ST_EXE) & src_clip &
    ((kind_q == K_REG) | ((kind_q == K_XMEM) & ~dir_q));
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      alu_input_x_first_q <= `PMD_RST_WORD;
      alu_input_x_second_q <= `PMD_RST_WORD;
      alu_input_y_first_q <= `PMD_RST_WORD;
      alu_input_y_second_q <= `PMD_RST_WORD;
      acc_one_q <= 56'h0;
      acc_two_q <= 56'h0;
      ccr_limit_q <= 1'b0;
      alu_wa_q <= 1'b0;
      alu_wb_q <= 1'b0;
      alu_res_q <= 56'h0;
    end else begin
      // set wins over clear; update moves never reach lim_event
      ccr_limit_q <= lim_event | (ccr_limit_q & ~limit_clear);
      if (take) begin
        alu_wa_q <= alu_wr_a;
        alu_wb_q <= alu_wr_b;
        alu_res_q <= alu_result;
      end
      if (state_q == ST_EXE && alu_wa_q) begin
        acc_one_q <= alu_res_q;
      end
      if (state_q == ST_EXE && alu_wb_q) begin
        acc_two_q <= alu_res_q;
      end
      if (wr_en) begin
        case (dst_q)
          `PMD_RC_X0: alu_input_x_first_q <= wr_val;
          `PMD_RC_X1: alu_input_x_second_q <= wr_val;
          `PMD_RC_Y0: alu_input_y_first_q <= wr_val;
          `PMD_RC_Y1: alu_input_y_second_q <= wr_val;
          `PMD_RC_A0: acc_one_q[23:0] <= wr_val;
          `PMD_RC_B0: acc_two_q[23:0] <= wr_val;
          `PMD_RC_A2: acc_one_q[55:48] <= wr_val[7:0];
          `PMD_RC_B2: acc_two_q[55:48] <= wr_val[7:0];
          `PMD_RC_A1: acc_one_q[47:24] <= wr_val;
          `PMD_RC_B1: acc_two_q[47:24] <= wr_val;
          `PMD_RC_A: acc_one_q <= {{8{wr_val[23]}}, wr_val, 24'h000000};
          `PMD_RC_B: acc_two_q <= {{8{wr_val[23]}}, wr_val, 24'h000000};
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // address registers with one instruction of delay
  // ---------------------------------------------------------------
  // pending writes commit at the next instruction's execute edge, after
  // that instruction has read the old values
  wire commit = (state_q == ST_EXE);
  wire new_upd = commit & ea_upd & ((kind_q == K_UPD) | ((kind_q == K_XMEM) & ~short_q));
  wire new_dst = wr_en & dst_q[4];
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      upd_pend_q <= 1'b0;
      upd_idx_q <= 3'h0;
      upd_val_q <= {AW{1'b0}};
      dst_pend_q <= 1'b0;
      dst_off_q <= 1'b0;
      dst_idx_q <= 3'h0;
      dst_val_q <= {AW{1'b0}};
    end else begin
      if (commit) begin
        upd_pend_q <= new_upd;
        upd_idx_q <= ea_idx;
        upd_val_q <= ea_new;
      end
      if (commit) begin
        dst_pend_q <= new_dst;
      end else if (new_dst) begin
        dst_pend_q <= 1'b1;
      end
      if (new_dst) begin
        dst_off_q <= dst_q[3];
        dst_idx_q <= dst_q[2:0];
        dst_val_q <= wr_val[AW-1:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_addr
      // a move write to the same pointer overrides its ea update
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          address_pointers[gi] <= {AW{1'b0}};
          address_offsets[gi] <= {AW{1'b0}};
        end else if (commit) begin
          if (dst_pend_q && !dst_off_q && dst_idx_q == gi) begin
            address_pointers[gi] <= dst_val_q;
          end else if (upd_pend_q && upd_idx_q == gi) begin
            address_pointers[gi] <= upd_val_q;
          end
          if (dst_pend_q && dst_off_q && dst_idx_q == gi) begin
            address_offsets[gi] <= dst_val_q;
          end
        end
      end
    end
  endgenerate

  // registered debug view of committed address registers
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dbg_data_q <= {AW{1'b0}};
    end else begin
      dbg_data_q <= dbg_sel[3] ? address_offsets[dbg_sel[2:0]] : address_pointers[dbg_sel[2:0]];
    end
  end
endmodule // pmd_decode

// File: verif/pmd_decode_props.sv
// concurrent checks on the parallel move decoder ports
`timescale 1ns/1ps
`include "pmd_map.vh"
module pmd_decode_props #(
  parameter AW = 16
) (
  input wire clk_sys,
  input wire nrst,
  input wire instr_valid,
  input wire [23:0] instr_word,
  input wire ext_valid,
  input wire [23:0] ext_word,
  input wire [23:0] mem_rdata,
  input wire alu_wr_a,
  input wire alu_wr_b,
  input wire [55:0] alu_result,
  input wire limit_clear,
  input wire [3:0] dbg_sel,
  input wire ready_q,
  input wire ext_req_q,
  input wire done_q,
  input wire [AW-1:0] mem_addr_q,
  input wire [23:0] mem_wdata_q,
  input wire mem_we_q,
  input wire mem_re_q,
  input wire ccr_limit_q
);
  // ----------------------------------------
  // handshake, strobe and flag checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // take edge and address update opcode match
  wire take = instr_valid && ready_q;
  wire upd_op = (instr_word[23:8] & `PMD_UPD_MASK) == `PMD_UPD_PAT;

  a_take_done_bound: assert property (take |-> ##[2:20] done_q)
    else $error("instruction never completed");
  a_done_single: assert property (done_q |=> !done_q)
    else $error("done held longer than one cycle");
  a_done_ready: assert property (done_q |-> ready_q)
    else $error("done without ready");
  a_write_strobe: assert property (mem_we_q |-> done_q && !mem_re_q)
    else $error("write strobe outside completion");
  a_read_then_done: assert property (mem_re_q |=> done_q)
    else $error("read not completed next cycle");
  a_ext_hold: assert property (ext_req_q && !ext_valid |=> ext_req_q)
    else $error("extension request dropped early");
  a_ext_consume: assert property (ext_req_q && ext_valid |=> !ext_req_q)
    else $error("extension word not consumed");
  a_limit_sticky: assert property (ccr_limit_q && !limit_clear |=> ccr_limit_q)
    else $error("limit flag lost");
  a_update_flags: assert property (take && upd_op && !limit_clear |=> $stable(ccr_limit_q) [*2])
    else $error("update move changed limit flag");
  a_update_no_mem: assert property (take && upd_op |=> (!mem_we_q && !mem_re_q) [*2])
    else $error("update move touched memory");

  // main scenarios reached
  c_ext_used: cover property (ext_req_q && ext_valid);
  c_mem_read: cover property (mem_re_q);
  c_limit_set: cover property ($rose(ccr_limit_q));
endmodule // pmd_decode_props

bind pmd_decode pmd_decode_props #(.AW(AW)) u_pmd_decode_props (
  .clk_sys(clk_sys), .nrst(nrst), .instr_valid(instr_valid), .instr_word(instr_word),
  .ext_valid(ext_valid), .ext_word(ext_word), .mem_rdata(mem_rdata), .alu_wr_a(alu_wr_a),
  .alu_wr_b(alu_wr_b), .alu_result(alu_result), .limit_clear(limit_clear), .dbg_sel(dbg_sel),
  .ready_q(ready_q), .ext_req_q(ext_req_q), .done_q(done_q), .mem_addr_q(mem_addr_q),
  .mem_wdata_q(mem_wdata_q), .mem_we_q(mem_we_q), .mem_re_q(mem_re_q), .ccr_limit_q(ccr_limit_q)
);

// File: verif/pmd_seq_model.sv
// sequencer extension supply and first data memory model
`timescale 1ns/1ps
module pmd_seq_model (
  input wire clk_sys,
  input wire nrst,
  input wire ext_req_q,
  input wire [23:0] ext_data,
  input wire [1:0] ext_wait,
  output reg ext_valid,
  output wire [23:0] ext_word,
  input wire [15:0] mem_addr_q,
  input wire [23:0] mem_wdata_q,
  input wire mem_we_q,
  input wire mem_re_q,
  output wire [23:0] mem_rdata,
  output reg [15:0] wr_addr,
  output reg [23:0] wr_data
);
  // ----------------------------------------
  // extension word supply
  // ----------------------------------------
  reg [1:0] cnt_q;
  reg re_d_q;
  reg [23:0] last_q;
  reg [23:0] mem [0:65535];
  // answer after ext_wait cycles, one word per request
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ext_valid <= 1'b0;
      cnt_q <= 2'h0;
    end else if (ext_req_q && !ext_valid) begin
      if (cnt_q == ext_wait) ext_valid <= 1'b1;
      else cnt_q <= cnt_q + 2'h1;
    end else begin
      ext_valid <= 1'b0;
      cnt_q <= 2'h0;
    end
  end
  // word is garbage outside its valid cycle, never a stale copy
  assign ext_word = ext_valid ? ext_data : ~ext_data;

  // ----------------------------------------
  // synchronous memory
  // ----------------------------------------
  // data shown during the strobe and held one cycle, so either sampling point works
  assign mem_rdata = mem_re_q ? mem[mem_addr_q] : (re_d_q ? last_q : ~last_q);
  // store writes and remember the last one for the bench
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      re_d_q <= 1'b0;
      last_q <= 24'h000000;
      wr_addr <= 16'h0000;
      wr_data <= 24'h000000;
    end else begin
      re_d_q <= mem_re_q;
      if (mem_re_q) last_q <= mem[mem_addr_q];
      if (mem_we_q) begin
        mem[mem_addr_q] <= mem_wdata_q;
        wr_addr <= mem_addr_q;
        wr_data <= mem_wdata_q;
      end
    end
  end
endmodule // pmd_seq_model

// File: verif/tb.sv
// self-checking bench for the parallel move decoder
`timescale 1ns/1ps
`include "pmd_map.vh"
module tb;
  reg clk_sys = 1'b0;
  reg nrst = 1'b0;
  reg instr_valid = 1'b0;
  reg [23:0] instr_word = 24'h000000;
  reg alu_wr_a = 1'b0;
  reg alu_wr_b = 1'b0;
  reg [55:0] alu_result = 56'h00000000000000;
  reg limit_clear = 1'b0;
  reg [3:0] dbg_sel = 4'h0;
  reg [23:0] ext_data = 24'h000000;
  reg [1:0] ext_wait = 2'h0;
  wire ext_valid, ready_q, ext_req_q, done_q, mem_we_q, mem_re_q, ccr_limit_q;
  wire [23:0] ext_word, mem_rdata, mem_wdata_q, wr_data, x0_q, x1_q, y0_q, y1_q;
  wire [15:0] mem_addr_q, dbg_data_q, wr_addr;
  wire [55:0] acc_one_q, acc_two_q;
  integer error_cnt = 0;
  integer check_count = 0;
  integer m;
  reg [15:0] p;

  // ----------------------------------------
  // clock, design and partner
  // ----------------------------------------
  always #10 clk_sys = ~clk_sys;
  pmd_decode #(.AW(16)) u_pmd_decode (.clk_sys(clk_sys), .nrst(nrst), .instr_valid(instr_valid),
    .instr_word(instr_word), .ext_valid(ext_valid), .ext_word(ext_word), .mem_rdata(mem_rdata),
    .alu_wr_a(alu_wr_a), .alu_wr_b(alu_wr_b), .alu_result(alu_result), .limit_clear(limit_clear),
    .dbg_sel(dbg_sel), .ready_q(ready_q), .ext_req_q(ext_req_q), .done_q(done_q),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_we_q(mem_we_q), .mem_re_q(mem_re_q),
    .ccr_limit_q(ccr_limit_q), .alu_input_x_first_q(x0_q), .alu_input_x_second_q(x1_q),
    .alu_input_y_first_q(y0_q), .alu_input_y_second_q(y1_q), .acc_one_q(acc_one_q),
    .acc_two_q(acc_two_q), .dbg_data_q(dbg_data_q));
  pmd_seq_model u_pmd_seq_model (.clk_sys(clk_sys), .nrst(nrst), .ext_req_q(ext_req_q),
    .ext_data(ext_data), .ext_wait(ext_wait), .ext_valid(ext_valid), .ext_word(ext_word),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_we_q(mem_we_q), .mem_re_q(mem_re_q),
    .mem_rdata(mem_rdata), .wr_addr(wr_addr), .wr_data(wr_data));

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  // value comparison, widths zero extended
  task chk(input [55:0] got, input [55:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one instruction: wait for ready, offer for one edge, then wait bounded for done plus one settle edge
  task issue(input [23:0] w);
    integer n;
    begin
      n = 0;
      while (ready_q !== 1'b1 && n < 20) begin
        @(posedge clk_sys);
        #1;
        n = n + 1;
      end
      if (n == 20) chk(56'h0, 56'h1);
      instr_word = w;
      instr_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      instr_valid = 1'b0;
      instr_word = ~w;
      alu_wr_a = 1'b0;
      alu_wr_b = 1'b0;
      n = 0;
      while (done_q !== 1'b1 && n < 30) begin
        @(posedge clk_sys);
        #1;
        n = n + 1;
      end
      if (n == 30) chk(56'h0, 56'h1);
      @(posedge clk_sys);
      #1;
    end
  endtask
  // immediate load, extension answered promptly or slowly by turns
  task imm(input [4:0] c, input [23:0] v);
    begin
      ext_data = v;
      ext_wait = ext_wait ^ 2'h2;
      issue({2'b01, c[4:3], 1'b0, c[2:0], 2'b11, `PMD_EA_IMM_CODE, 8'h00});
    end
  endtask
  // memory move: code, direction, long flag, mode field
  task xm(input [4:0] c, input w, input l, input [5:0] f);
    issue({2'b01, c[4:3], 1'b0, c[2:0], w, l, f, 8'h00});
  endtask
  // committed address register through the debug port
  task chk_ar(input [3:0] s, input [15:0] e);
    begin
      dbg_sel = s;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(dbg_data_q, e);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  // watchdog well past the expected few hundred cycles
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 nrst = 1'b1;
    @(posedge clk_sys);
    #1;
    imm(`PMD_RC_Y1, 24'h001234);
    chk(y1_q, 24'h001234);
    issue({6'h08, `PMD_RC_Y1, 5'h1d, 8'h00});
    issue(24'h000000);
    chk_ar(4'hd, 16'h1234);
    imm(5'h13, 24'habcdef);
    imm(5'h1b, 24'h000004);
    issue(24'h000000);
    chk_ar(4'h3, 16'hcdef);
    issue({6'h08, 5'h13, `PMD_RC_X0, 8'h00});
    chk(x0_q, 24'h00cdef);
    $display("test register moves done");
    p = 16'hcdef;
    for (m = 0; m < 4; m = m + 1) begin
      issue({11'h102, m[1:0], 3'd3, 8'h00});
      issue(24'h000000);
      p = (m == 0) ? p - 16'h0004 : (m == 1) ? p + 16'h0004 : (m == 2) ? p - 16'h0001 : p + 16'h0001;
      chk_ar(4'h3, p);
    end
    chk_ar(4'hb, 16'h0004);
    $display("test address update done");
    imm(5'h12, 24'h000010);
    issue(24'h000000);
    imm(5'h12, 24'h000020);
    xm(`PMD_RC_X0, 1'b0, 1'b1, 6'h22);
    chk(wr_addr, 16'h0010);
    chk(wr_data, 24'h00cdef);
    issue(24'h000000);
    xm(`PMD_RC_X0, 1'b0, 1'b1, 6'h22);
    chk(wr_addr, 16'h0020);
    imm(5'h12, 24'h001001);
    issue(24'h000000);
    xm(5'h12, 1'b0, 1'b1, 6'h3a);
    chk(wr_addr, 16'h1000);
    chk(wr_data, 24'h001000);
    xm(`PMD_RC_X0, 1'b0, 1'b0, 6'h3f);
    chk(wr_addr, 16'h003f);
    xm(`PMD_RC_X0, 1'b0, 1'b1, 6'h2b);
    chk(wr_addr, 16'hcdf3);
    xm(`PMD_RC_Y0, 1'b1, 1'b0, 6'h3f);
    chk(y0_q, 24'h00cdef);
    ext_data = 24'h001234;
    xm(`PMD_RC_Y0, 1'b0, 1'b1, `PMD_EA_ABS_CODE);
    chk(wr_addr, 16'h1234);
    xm(`PMD_RC_X1, 1'b1, 1'b1, `PMD_EA_ABS_CODE);
    chk(x1_q, 24'h00cdef);
    $display("test memory moves done");
    imm(`PMD_RC_A, 24'h400000);
    chk(acc_one_q, 56'h00400000000000);
    imm(`PMD_RC_B, 24'h800000);
    chk(acc_two_q, 56'hff800000000000);
    alu_wr_a = 1'b1; // arithmetic writes one accumulator, the move the other
    alu_result = 56'h01000000000000;
    issue({6'h08, `PMD_RC_X0, `PMD_RC_B, 8'h00});
    chk(acc_one_q, 56'h01000000000000);
    chk(acc_two_q, 56'h0000cdef000000);
    xm(`PMD_RC_A, 1'b0, 1'b1, 6'h22);
    chk(wr_data, 24'h7fffff);
    chk(ccr_limit_q, 1'b1);
    issue({11'h102, 2'b11, 3'd3, 8'h00});
    chk(ccr_limit_q, 1'b1);
    limit_clear = 1'b1;
    @(posedge clk_sys);
    #1 limit_clear = 1'b0;
    chk(ccr_limit_q, 1'b0);
    alu_wr_a = 1'b1;
    alu_result = 56'hfe000000000000;
    issue(24'h000000);
    xm(`PMD_RC_A, 1'b0, 1'b1, 6'h22);
    chk(wr_data, 24'h800000);
    // move reads the accumulator the arithmetic rewrites in the same instruction
    alu_wr_a = 1'b1;
    alu_result = 56'h00000000000000;
    issue({6'h08, `PMD_RC_A, `PMD_RC_Y1, 8'h00});
    chk(y1_q, 24'h800000);
    chk(acc_one_q, 56'h00000000000000);
    $display("test accumulator limiting done");
    tally_and_finish;
  end
endmodule // tb
